// >>> hw/had_pkg.sv
// Package for the headset accessory detect block: register map, fields, timing.
// Assumes an APB master on pclk at 100 MHz with 32-bit data.
package had_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] HAD_CTRL_OFS = 12'h000;
    localparam logic [11:0] HAD_MASK_OFS = 12'h004;
    localparam logic [11:0] HAD_STAT_OFS = 12'h008;
    localparam logic [11:0] HAD_STATE_OFS = 12'h00c;
    // ==========================================================
    // Control fields
    localparam int HAD_C_STR = 0;
    localparam int HAD_C_VCE = 1;
    localparam int HAD_C_B1 = 2;
    localparam int HAD_C_B2 = 3;
    localparam int HAD_C_BOOST = 4;
    localparam int HAD_C_DET = 5;
    localparam int HAD_C_AUD = 6;
    // Status and mask fields
    localparam int HAD_I_HP = 0;
    localparam int HAD_I_HS = 1;
    localparam int HAD_I_SHORT = 2;
    localparam int HAD_I_LONG = 3;
    localparam logic [6:0] HAD_CTRL_RST = 7'h00;
    localparam logic [3:0] HAD_MASK_RST = 4'h0;
    // ==========================================================
    // Timing
    localparam int HAD_CLK_MHZ = 100;
    localparam int HAD_TICK_US = 1000;
    localparam int HAD_TICK_CYC = HAD_TICK_US * HAD_CLK_MHZ;
    localparam int HAD_DEB_MS = 30;
    localparam int HAD_LONG_S = 2;
    localparam int HAD_DEB_TICKS = HAD_DEB_MS * 1000 / HAD_TICK_US;
    localparam int HAD_LONG_TICKS = HAD_LONG_S * 1000000 / HAD_TICK_US;
endpackage : had_pkg

// >>> hw/had_debounce.sv
// Debouncer for one synchronised detector level, counting timebase ticks.
// Assumes din already passed two flip-flops and tick is a one-cycle pulse.
`timescale 1ns/100ps
module had_debounce
    import had_pkg::*;
#(
    parameter int TICKS = 30
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in, tick, filtered level out
    input wire logic din,
    input wire logic tick,
    output logic dout
);
    typedef struct packed {
        logic q;
        logic [15:0] cnt;
    } had_deb_t;
    had_deb_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (din == st_ff.q) begin
            nxt_st.cnt = 16'h0000;
        end else if (tick) begin
            if (st_ff.cnt >= 16'(TICKS - 1)) begin
                nxt_st.q = din;
                nxt_st.cnt = 16'h0000;
            end else begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;
endmodule : had_debounce

// >>> hw/had_top.sv
// Audio front end control and headset accessory detector with an APB slave.
// Assumes jack sense inputs are asynchronous comparator levels from the analog side.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module had_top
    import had_pkg::*;
#(
    parameter int TICK_CYC = HAD_TICK_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Jack sense from the analog detector
    input wire logic jack_present,
    input wire logic jack_mic_load,
    // Analog controls
    output logic stereo_adc_power,
    output logic voice_mode,
    output logic mic_bias_one_out,
    output logic mic_bias_two_out,
    output logic mic_bias_one_boost_out,
    output logic detector_power,
    // Host interrupt
    output logic host_irq_pin
);
    // ==========================================================
    // State
    typedef enum logic [1:0] {HAD_EMPTY, HAD_PHONE, HAD_SET} had_acc_t;

    typedef struct packed {
        logic [6:0] ctrl;
        logic [3:0] mask;
        logic [3:0] stat;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic str_pwr;
        logic vmode;
        logic b1;
        logic b2;
        logic boost;
        logic detp;
        logic [16:0] div;
        logic tick;
        logic [1:0] s_pres;
        logic [1:0] s_mic;
        had_acc_t acc;
        logic btn_prev;
        logic [15:0] btn_cnt;
        logic btn_long;
    } had_st_t;
    had_st_t st_ff, nxt_st;

    logic pres_db;
    logic mic_db;

    // ==========================================================
    // Debounced detector levels
    had_debounce #(.TICKS(HAD_DEB_TICKS)) u_deb_pres (
        .pclk(pclk),
        .presetn(presetn),
        .din(st_ff.s_pres[1]),
        .tick(st_ff.tick),
        .dout(pres_db)
    );
    had_debounce #(.TICKS(HAD_DEB_TICKS)) u_deb_mic (
        .pclk(pclk),
        .presetn(presetn),
        .din(st_ff.s_mic[1]),
        .tick(st_ff.tick),
        .dout(mic_db)
    );

    function automatic logic had_hit(input logic [11:0] a, input logic [11:0] ofs);
        had_hit = (a == ofs);
    endfunction : had_hit

    // ==========================================================
    // Next state
    always_comb begin
        logic wr;
        logic rd;
        logic biases;
        logic btn;
        logic [3:0] set;
        logic [3:0] clr;
        wr = 1'b0;
        rd = 1'b0;
        biases = 1'b0;
        btn = 1'b0;
        set = 4'h0;
        clr = 4'h0;
        nxt_st = st_ff;

        // Two-flop synchronisers; only the second stage is read
        nxt_st.s_pres = {st_ff.s_pres[0], jack_present};
        nxt_st.s_mic = {st_ff.s_mic[0], jack_mic_load};

        // Free-running millisecond timebase
        if (st_ff.div >= 17'(TICK_CYC - 1)) begin
            nxt_st.div = 17'h00000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div = st_ff.div + 17'h00001;
            nxt_st.tick = 1'b0;
        end

        // APB: zero wait states, error on unmapped offset
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        nxt_st.ready = psel && !penable;
        nxt_st.err = 1'b0;
        if (psel && !penable) begin
            nxt_st.err = !(had_hit(paddr, HAD_CTRL_OFS) || had_hit(paddr, HAD_MASK_OFS)
                || had_hit(paddr, HAD_STAT_OFS) || had_hit(paddr, HAD_STATE_OFS));
        end
        if (rd) begin
            nxt_st.rdata = 32'h00000000;
            if (had_hit(paddr, HAD_CTRL_OFS)) nxt_st.rdata[6:0] = st_ff.ctrl;
            if (had_hit(paddr, HAD_MASK_OFS)) nxt_st.rdata[3:0] = st_ff.mask;
            if (had_hit(paddr, HAD_STAT_OFS)) nxt_st.rdata[3:0] = st_ff.stat;
            if (had_hit(paddr, HAD_STATE_OFS)) begin
                nxt_st.rdata[1:0] = st_ff.acc;
                nxt_st.rdata[2] = st_ff.btn_prev;
            end
        end
        if (wr && had_hit(paddr, HAD_CTRL_OFS)) nxt_st.ctrl = pwdata[6:0];
        if (wr && had_hit(paddr, HAD_MASK_OFS)) nxt_st.mask = pwdata[3:0];
        if (wr && had_hit(paddr, HAD_STAT_OFS)) clr = pwdata[3:0];

        // Analog enables
        nxt_st.str_pwr = st_ff.ctrl[HAD_C_STR] && !st_ff.ctrl[HAD_C_VCE];
        nxt_st.vmode = st_ff.ctrl[HAD_C_VCE];
        nxt_st.b1 = st_ff.ctrl[HAD_C_B1];
        nxt_st.b2 = st_ff.ctrl[HAD_C_B2];
        nxt_st.boost = st_ff.ctrl[HAD_C_B1] && st_ff.ctrl[HAD_C_BOOST];
        nxt_st.detp = st_ff.ctrl[HAD_C_DET];

        // Classification needs audio bias and second mic bias
        biases = st_ff.ctrl[HAD_C_AUD] && st_ff.ctrl[HAD_C_B2];
        // A low-impedance load on a headset is the button pressed
        btn = (st_ff.acc == HAD_SET) && biases && !mic_db;

        if (st_ff.ctrl[HAD_C_DET]) begin
            unique case (st_ff.acc)
                HAD_EMPTY: begin
                    if (pres_db) begin
                        // Button held at insertion looks like a headphone
                        if (biases && mic_db) begin
                            nxt_st.acc = HAD_SET;
                            set[HAD_I_HS] = 1'b1;
                        end else begin
                            nxt_st.acc = HAD_PHONE;
                            set[HAD_I_HP] = 1'b1;
                        end
                    end
                end
                HAD_PHONE: begin
                    if (!pres_db) begin
                        nxt_st.acc = HAD_EMPTY;
                        set[HAD_I_HP] = 1'b1;
                    end else if (biases && mic_db) begin
                        nxt_st.acc = HAD_SET;
                        clr[HAD_I_HP] = 1'b1;
                        set[HAD_I_HS] = 1'b1;
                    end
                end
                HAD_SET: begin
                    if (!pres_db) begin
                        nxt_st.acc = HAD_EMPTY;
                        set[HAD_I_HS] = 1'b1;
                    end
                end
            endcase
        end else begin
            nxt_st.acc = HAD_EMPTY;
        end

        // Button duration, counted from the debounced press edge
        nxt_st.btn_prev = btn;
        if (btn && !st_ff.btn_prev) begin
            nxt_st.btn_cnt = 16'h0000;
            nxt_st.btn_long = 1'b0;
        end else if (btn && st_ff.tick && !st_ff.btn_long) begin
            if (st_ff.btn_cnt >= 16'(HAD_LONG_TICKS - 1)) begin
                nxt_st.btn_long = 1'b1;
            end else begin
                nxt_st.btn_cnt = st_ff.btn_cnt + 16'h0001;
            end
        end
        if (!btn && st_ff.btn_prev && st_ff.acc == HAD_SET && mic_db) begin
            if (st_ff.btn_long) begin
                set[HAD_I_LONG] = 1'b1;
            end else begin
                set[HAD_I_SHORT] = 1'b1;
            end
        end

        // Sticky status, set wins over a software clear in the same cycle
        nxt_st.stat = (st_ff.stat & ~clr) | set;
        nxt_st.irq = |(nxt_st.stat & ~st_ff.mask);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.err;
    assign stereo_adc_power = st_ff.str_pwr;
    assign voice_mode = st_ff.vmode;
    assign mic_bias_one_out = st_ff.b1;
    assign mic_bias_two_out = st_ff.b2;
    assign mic_bias_one_boost_out = st_ff.boost;
    assign detector_power = st_ff.detp;
    assign host_irq_pin = st_ff.irq;
endmodule : had_top

// >>> sim/had_jack_model.sv
// Jack accessory model: headphone or headset with a button.
// Assumes the bench sets plug, kind and button; bias comes from the block.
`timescale 1ns/100ps
module had_jack_model (
    // Commands from the bench
    input wire logic plug,
    input wire logic hset,
    input wire logic btn,
    // Bias from the block
    input wire logic bias_on,
    // Sense lines to the block
    output logic jack_present,
    output logic jack_mic_load
);
    // ==========================================
    // Sense levels
    // Mic load only shows with bias on; a pressed button shorts it low.
    // An empty jack has a pull-down on the mic ring.
    assign jack_present = plug;
    assign jack_mic_load = plug & hset & !btn & bias_on;
endmodule : had_jack_model

// >>> sim/had_top_assertions.sv
// Port checker for the accessory detect top.
// Assumes a well behaved APB master and clean jack inputs.
`timescale 1ns/100ps
module had_assertions
    import had_pkg::*;
#(
    parameter int TICK_CYC = HAD_TICK_CYC
) (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Jack sense
    input wire logic jack_present,
    input wire logic jack_mic_load,
    // Outputs
    input wire logic stereo_adc_power,
    input wire logic voice_mode,
    input wire logic mic_bias_one_out,
    input wire logic mic_bias_two_out,
    input wire logic mic_bias_one_boost_out,
    input wire logic host_irq_pin
);
    // ==========================================
    // Quiet time since the last jack change
    // One tick of slack: the timebase phase is unknown to the checker.
    localparam int DEB = (HAD_DEB_TICKS - 1) * TICK_CYC;
    logic [1:0] jk_ff;
    logic [31:0] quiet_ff;
    wire wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jk_ff <= 2'h0;
            quiet_ff <= 32'h0;
        end else begin
            jk_ff <= {jack_present, jack_mic_load};
            if (jk_ff != {jack_present, jack_mic_load})
                quiet_ff <= 32'h0;
            else if (quiet_ff != 32'hffffffff)
                quiet_ff <= quiet_ff + 32'h1;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_STR_WRITE: assert property ($rose(stereo_adc_power) |->
        $past(wr, 1) || $past(wr, 2)) else $error("stereo power rose without write");
    AST_VOICE_WINS: assert property (stereo_adc_power |-> !voice_mode)
        else $error("stereo power in voice mode");
    AST_BIAS_WRITE: assert property ($changed({mic_bias_one_out, mic_bias_two_out}) |->
        $past(wr, 1) || $past(wr, 2)) else $error("bias moved without write");
    AST_BOOST_B1: assert property (mic_bias_one_boost_out |-> mic_bias_one_out)
        else $error("boost without first bias");
    AST_DEBOUNCE: assert property ($rose(host_irq_pin) && !$past(wr, 1) &&
        !$past(wr, 2) |-> quiet_ff >= DEB) else $error("event before debounce");
    AST_PIN_FALL: assert property ($fell(host_irq_pin) |->
        $past(wr, 1) || $past(wr, 2)) else $error("irq pin fell without write");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside access");
endmodule : had_assertions

bind had_top had_assertions #(.TICK_CYC(TICK_CYC)) i_chk (.*);

// >>> sim/headset_accessory_detect_tb.sv
// Testbench for the accessory detect top with a jack model.
// Assumes a 1 ms tick shortened to 10 cycles.
`timescale 1ns/100ps
module headset_accessory_detect_tb
    import had_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, jack_present, jack_mic_load, host_irq_pin;
    logic stereo_adc_power, voice_mode, mic_bias_one_out, mic_bias_two_out;
    logic mic_bias_one_boost_out, detector_power;
    logic plug = 0, hset = 0, btn = 0;
    int errors = 0, n_checks = 0;
    logic [6:0] r_ctl [8] = '{7'h01, 7'h03, 7'h02, 7'h04, 7'h08, 7'h14, 7'h10, 7'h20};
    logic [5:0] r_out [8] = '{6'h20, 6'h10, 6'h10, 6'h08, 6'h04, 6'h0a, 6'h00, 6'h01};
    always #5 pclk = ~pclk;
    had_top #(.TICK_CYC(10)) i_dut (.*);
    had_jack_model i_jack (.plug(plug), .hset(hset), .btn(btn), .bias_on(mic_bias_two_out),
        .jack_present(jack_present), .jack_mic_load(jack_mic_load));
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look at pready mid-cycle; at the edge itself it races the slave update
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        @(posedge pclk);
        r = prdata;
        e = pslverr;
        if (n >= 20)
            errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask : rd
    task automatic settle;
        repeat (400) @(posedge pclk);
    endtask : settle
    task automatic clr;
        apb(1'b1, HAD_STAT_OFS, 32'hf);
    endtask : clr
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // ==========================================
    // Watchdog: whole run is near 26000 cycles
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        give_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(HAD_CTRL_OFS, 32'h0);
        rd(HAD_MASK_OFS, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, HAD_CTRL_OFS, {25'h0, r_ctl[i]});
            repeat (2) @(posedge pclk);
            chk({26'h0, stereo_adc_power, voice_mode, mic_bias_one_out, mic_bias_two_out,
                mic_bias_one_boost_out, detector_power}, {26'h0, r_out[i]});
            rd(HAD_CTRL_OFS, {25'h0, r_ctl[i]});
        end
        $display("test control rows done");
        plug <= 1'b1;
        settle();
        rd(HAD_STAT_OFS, 32'h1);
        chk({31'h0, host_irq_pin}, 32'h1);
        clr();
        plug <= 1'b0;
        settle();
        rd(HAD_STAT_OFS, 32'h1);
        clr();
        hset <= 1'b1;
        plug <= 1'b1;
        settle();
        rd(HAD_STATE_OFS, 32'h1);
        apb(1'b1, HAD_CTRL_OFS, 32'h68);
        settle();
        rd(HAD_STAT_OFS, 32'h2);
        rd(HAD_STATE_OFS, 32'h2);
        $display("test detect done");
        for (int k = 0; k < 2; k++) begin
            clr();
            btn <= 1'b1;
            repeat (k ? 21000 : 1000) @(posedge pclk);
            btn <= 1'b0;
            settle();
            rd(HAD_STAT_OFS, k ? 32'h8 : 32'h4);
        end
        $display("test button done");
        clr();
        apb(1'b1, HAD_MASK_OFS, 32'hf);
        plug <= 1'b0;
        settle();
        rd(HAD_STAT_OFS, 32'h2);
        chk({31'h0, host_irq_pin}, 32'h0);
        apb(1'b1, HAD_MASK_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, host_irq_pin}, 32'h1);
        clr();
        btn <= 1'b1;
        plug <= 1'b1;
        settle();
        rd(HAD_STAT_OFS, 32'h1);
        btn <= 1'b0;
        settle();
        rd(HAD_STAT_OFS, 32'h2);
        $display("test mask and held button done");
        give_verdict();
    end
endmodule : headset_accessory_detect_tb
